// ### hdl/eipu_pkg.sv
// Behaviour
// - Pin activity raises requests even when the pin is driven as an output.
// - Enabled level mode requests while the pin stays low and no power-down wake is running.
// - Edge modes need the I/O clock; low level is detected without it.
// - Power-down level wake samples the level twice on watchdog ticks.
// - Level gone before start-up ends: wake still happens, no level request.
// - Second pin sense in control bits 3:2: low, change, fall, rise.
// - First pin sense in control bits 1:0 with the same encoding.
// - Pin is sampled before edge detection; pulses over one clock caught.
// - Second pin request needs enable bit 7 and the global interrupt bit.
// - First pin request needs enable bit 6 and the global interrupt bit.
// - Event on the second pin sets flag bit 7.
// - Event on the first pin sets flag bit 6.
// - Flag clears on vector entry or by writing one; zero does nothing.
// - A pin in level mode always reads its flag as cleared.
// - Control register is eight bits read/write, reset to zero.
`default_nettype none

package eipu_pkg;

    // ==========================================================
    // Register map
    localparam logic [3:0] CTRL_OFS  = 4'h0;
    localparam logic [3:0] EN_OFS    = 4'h4;
    localparam logic [3:0] FLAG_OFS  = 4'h8;
    localparam logic [3:0] STAT_OFS  = 4'hc;
    localparam logic [7:0] CTRL_RST  = 8'h00;
    localparam logic [7:0] EN_RST    = 8'h00;
    localparam logic [7:0] FLAG_RST  = 8'h00;
    localparam int         EN_A_BIT  = 6;
    localparam int         EN_B_BIT  = 7;
    localparam int         FLAG_A_BIT = 6;
    localparam int         FLAG_B_BIT = 7;
    localparam int         NUM_PINS  = 2;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        SENSE_LOW  = 2'b00,
        SENSE_ANY  = 2'b01,
        SENSE_FALL = 2'b10,
        SENSE_RISE = 2'b11
    } eipu_sense_t;

    typedef struct packed {
        logic        sleep_allow;
        logic        sleep_select_2;
        logic        sleep_select_1;
        logic        sleep_select_0;
        eipu_sense_t pin_b_sense;
        eipu_sense_t pin_a_sense;
    } eipu_ctrl_t;

    typedef enum logic [1:0] {
        WK_IDLE    = 2'b00,
        WK_FIRST   = 2'b01,
        WK_STARTUP = 2'b10
    } eipu_wake_t;

endpackage : eipu_pkg

`default_nettype wire

// ### hdl/eipu_pin_detect.sv
`default_nettype none

module eipu_pin_detect (
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    input  wire logic                 pin_raw,
    input  wire eipu_pkg::eipu_sense_t sense,
    input  wire logic                 io_clock_running,
    output logic                      event_pulse,
    output logic                      pin_low
);

    // ==========================================================
    // Synchroniser and history
    logic sync1_ff;
    logic sync2_ff;
    logic prev_ff;
    logic rise;
    logic fall;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sync1_ff <= 1'b1;
            sync2_ff <= 1'b1;
            prev_ff  <= 1'b1;
        end else begin
            sync1_ff <= pin_raw;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    assign rise = sync2_ff & ~prev_ff;
    assign fall = ~sync2_ff & prev_ff;

    // ==========================================================
    // Edge decode, only while the I/O clock runs
    always_comb begin
        event_pulse = 1'b0;
        unique case (sense)
            eipu_pkg::SENSE_LOW:  event_pulse = 1'b0;
            eipu_pkg::SENSE_ANY:  event_pulse = rise | fall;
            eipu_pkg::SENSE_FALL: event_pulse = fall;
            eipu_pkg::SENSE_RISE: event_pulse = rise;
        endcase
        event_pulse = event_pulse & io_clock_running;
    end

    // Raw level bypasses all flops so a stopped clock still sees it
    assign pin_low = ~pin_raw;

endmodule : eipu_pin_detect

`default_nettype wire

// ### hdl/eipu_top.sv
// The implementer's own choices: the Avalon-MM slave port and the register offsets.
`default_nettype none

module eipu_top (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        ext_irq_pin_a,
    input  wire logic        ext_irq_pin_b,
    input  wire logic        global_irq_enable,
    input  wire logic        io_clock_running,
    input  wire logic [1:0]  irq_vector_entered,
    input  wire logic        power_down,
    input  wire logic        wdt_tick,
    input  wire logic        startup_done,
    output logic      [1:0]  irq_request,
    output logic             wake_up,
    output logic      [3:0]  sleep_ctrl
);

    // ==========================================================
    // Declarations
    eipu_pkg::eipu_ctrl_t  ctrl_ff;
    logic [7:0]            enable_ff;
    logic [7:0]            flags_ff;
    logic [7:0]            nxt_flags;
    logic                  ack_ff;
    logic [31:0]           rdata_ff;
    logic [31:0]           nxt_rdata;
    eipu_pkg::eipu_wake_t  wake_ff;
    eipu_pkg::eipu_wake_t  nxt_wake;
    logic                  req_any;
    logic                  wr_take;
    logic                  wr_ctrl;
    logic                  wr_en;
    logic                  wr_flag;
    logic [1:0]            pins;
    logic [1:0]            pin_event;
    logic [1:0]            pin_low;
    logic [1:0]            level_mode;
    logic [1:0]            pin_en;
    logic [1:0]            pin_flag;
    logic [1:0]            flag_clr;
    logic [1:0]            wake_low;
    logic                  any_wake_low;
    eipu_pkg::eipu_sense_t sense [2];

    // ==========================================================
    // Avalon-MM slave: one wait cycle, then the answer
    assign req_any         = avs_read | avs_write;
    assign avs_waitrequest = req_any & ~ack_ff;
    assign wr_take         = avs_write & ack_ff;
    assign wr_ctrl         = wr_take & (avs_address == eipu_pkg::CTRL_OFS);
    assign wr_en           = wr_take & (avs_address == eipu_pkg::EN_OFS);
    assign wr_flag         = wr_take & (avs_address == eipu_pkg::FLAG_OFS);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req_any & ~ack_ff;
        end
    end

    // Read data is captured in the wait cycle, so it already stands
    // at the edge where waitrequest is seen low
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        unique case (avs_address)
            eipu_pkg::CTRL_OFS: nxt_rdata[7:0] = ctrl_ff;
            eipu_pkg::EN_OFS:   nxt_rdata[7:0] = enable_ff;
            eipu_pkg::FLAG_OFS: nxt_rdata[7:0] = flags_ff;
            eipu_pkg::STAT_OFS: nxt_rdata[7:0] = {4'h0, irq_request, ~pins};
            default:            nxt_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdata_ff <= 32'h0000_0000;
        end else if (avs_read & ~ack_ff) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign avs_readdata = rdata_ff;

    // ==========================================================
    // Control and enable registers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctrl_ff <= eipu_pkg::eipu_ctrl_t'(eipu_pkg::CTRL_RST);
        end else if (wr_ctrl) begin
            ctrl_ff <= eipu_pkg::eipu_ctrl_t'(avs_writedata[7:0]);
        end
    end

    // Only the two enable bits exist; the rest read as zero
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            enable_ff <= eipu_pkg::EN_RST;
        end else if (wr_en) begin
            enable_ff <= 8'h00;
            enable_ff[eipu_pkg::EN_A_BIT] <= avs_writedata[eipu_pkg::EN_A_BIT];
            enable_ff[eipu_pkg::EN_B_BIT] <= avs_writedata[eipu_pkg::EN_B_BIT];
        end
    end

    // Sleep bits are only stored here and handed to the core
    assign sleep_ctrl = {ctrl_ff.sleep_allow, ctrl_ff.sleep_select_2,
                         ctrl_ff.sleep_select_1, ctrl_ff.sleep_select_0};

    // ==========================================================
    // Per pin mapping
    // Pins are read straight from the pad, whatever the port direction
    assign pins     = {ext_irq_pin_b, ext_irq_pin_a};
    assign sense[0] = ctrl_ff.pin_a_sense;
    assign sense[1] = ctrl_ff.pin_b_sense;
    assign pin_en   = {enable_ff[eipu_pkg::EN_B_BIT],
                       enable_ff[eipu_pkg::EN_A_BIT]};
    assign pin_flag = {flags_ff[eipu_pkg::FLAG_B_BIT],
                       flags_ff[eipu_pkg::FLAG_A_BIT]};

    // ==========================================================
    // Detection, flags and requests per pin
    for (genvar i = 0; i < eipu_pkg::NUM_PINS; i++) begin : g_pin
        eipu_pin_detect i_eipu_pin_detect (
            .clk              (clk),
            .reset_n          (reset_n),
            .pin_raw          (pins[i]),
            .sense            (sense[i]),
            .io_clock_running (io_clock_running),
            .event_pulse      (pin_event[i]),
            .pin_low          (pin_low[i])
        );

        assign level_mode[i] = (sense[i] == eipu_pkg::SENSE_LOW);

        // Vector entry or a written one clears the flag
        assign flag_clr[i] = irq_vector_entered[i] |
                             (wr_flag & avs_writedata[eipu_pkg::FLAG_A_BIT + i]);

        // A level request stays off while a power-down wake is still
        // running, so a level that vanishes early gives no request
        assign irq_request[i] = pin_en[i] & global_irq_enable &
                                (level_mode[i] ?
                                 (pin_low[i] & (wake_ff == eipu_pkg::WK_IDLE)) :
                                 pin_flag[i]);

        // Level wake only for enabled pins in level mode
        assign wake_low[i] = pin_en[i] & level_mode[i] & pin_low[i];
    end

    always_comb begin
        nxt_flags = 8'h00;
        for (int k = 0; k < eipu_pkg::NUM_PINS; k++) begin
            if (level_mode[k]) begin
                nxt_flags[eipu_pkg::FLAG_A_BIT + k] = 1'b0;
            end else if (pin_event[k]) begin
                // A new event wins over a clear in the same cycle
                nxt_flags[eipu_pkg::FLAG_A_BIT + k] = 1'b1;
            end else if (flag_clr[k]) begin
                nxt_flags[eipu_pkg::FLAG_A_BIT + k] = 1'b0;
            end else begin
                nxt_flags[eipu_pkg::FLAG_A_BIT + k] = pin_flag[k];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            flags_ff <= eipu_pkg::FLAG_RST;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    // ==========================================================
    // Power-down level wake
    // The level must be seen on two watchdog ticks in a row; this
    // filters noise at the cost of one extra tick of wake latency
    assign any_wake_low = |wake_low;

    always_comb begin
        nxt_wake = wake_ff;
        unique case (wake_ff)
            eipu_pkg::WK_IDLE: begin
                if (power_down & wdt_tick & any_wake_low) begin
                    nxt_wake = eipu_pkg::WK_FIRST;
                end
            end
            eipu_pkg::WK_FIRST: begin
                if (wdt_tick) begin
                    nxt_wake = any_wake_low ? eipu_pkg::WK_STARTUP
                                            : eipu_pkg::WK_IDLE;
                end
            end
            eipu_pkg::WK_STARTUP: begin
                if (startup_done) begin
                    nxt_wake = eipu_pkg::WK_IDLE;
                end
            end
            default: nxt_wake = eipu_pkg::WK_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wake_ff <= eipu_pkg::WK_IDLE;
        end else begin
            wake_ff <= nxt_wake;
        end
    end

    // Wake is kept up until start-up ends, even if the level is gone
    assign wake_up = (wake_ff == eipu_pkg::WK_STARTUP);

endmodule : eipu_top

`default_nettype wire

// ### testbench/eipu_checker.sv
`default_nettype none
// ==========
// Port checker
module eipu_checker (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        ext_irq_pin_a,
    input wire logic        ext_irq_pin_b,
    input wire logic        global_irq_enable,
    input wire logic        wdt_tick,
    input wire logic        power_down,
    input wire logic        startup_done,
    input wire logic [1:0]  irq_request,
    input wire logic        wake_up,
    input wire logic [3:0]  sleep_ctrl
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    req_a_gate_a: assert property (irq_request[0] |-> global_irq_enable)
        else $error("pin a request without global enable");
    req_b_gate_a: assert property (irq_request[1] |-> global_irq_enable)
        else $error("pin b request without global enable");
    wake_rise_a: assert property ($rose(wake_up) |-> $past(wdt_tick) && $past(power_down))
        else $error("wake without a watchdog sample");
    wake_hold_a: assert property (wake_up && !startup_done |=> wake_up)
        else $error("wake dropped before start-up end");
    sleep_write_a: assert property (avs_write && !avs_waitrequest && avs_address == 4'h0
        |=> sleep_ctrl == $past(avs_writedata[7:4])) else $error("sleep bits not written");
    unmapped_zero_a: assert property (avs_read && !avs_waitrequest
        && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    status_read_a: assert property (avs_read && !avs_waitrequest && avs_address == 4'hc
        |-> avs_readdata[3:0] == {$past(irq_request), ~$past(ext_irq_pin_b),
                                  ~$past(ext_irq_pin_a)})
        else $error("status read wrong");
    wait_once_a: assert property ($rose(avs_read) || $rose(avs_write)
        |-> avs_waitrequest ##1 !avs_waitrequest) else $error("bus wait not one cycle");
endmodule : eipu_checker

bind eipu_top eipu_checker i_eipu_checker (.clk, .reset_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .ext_irq_pin_a, .ext_irq_pin_b,
    .global_irq_enable, .wdt_tick, .power_down, .startup_done, .irq_request, .wake_up,
    .sleep_ctrl);
`default_nettype wire

// ### testbench/eipu_pin_source.sv
`default_nettype none
// ==========
// Pin sources, registered so a level always lasts whole clock periods
module eipu_pin_source (
    input  wire logic       clk,
    input  wire logic [1:0] pin_lvl,
    output logic            pin_a,
    output logic            pin_b
);
    timeunit 1ns;
    timeprecision 1ns;
    initial pin_a = 1'h1;
    initial pin_b = 1'h1;
    always @(posedge clk) begin
        pin_a <= pin_lvl[0];
        pin_b <= pin_lvl[1];
    end
endmodule : eipu_pin_source
`default_nettype wire

// ### testbench/eipu_bench.sv
`default_nettype none
// ==========
// Bench top
module eipu_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'h0, reset_n = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
    logic [3:0]  avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic        avs_waitrequest, pin_a, pin_b, wake;
    logic        glb = 1'h0, ioc = 1'h1, pdn = 1'h0, tick = 1'h0, sdone = 1'h0;
    logic [1:0]  pin_lvl = 2'h3, vec = 2'h0, irq;
    logic [3:0]  slp;
    int          err_total = 0, n_checks = 0;

    always #5 clk = ~clk;

    eipu_top i_eipu_top (.clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .ext_irq_pin_a(pin_a), .ext_irq_pin_b(pin_b),
        .global_irq_enable(glb), .io_clock_running(ioc), .irq_vector_entered(vec),
        .power_down(pdn), .wdt_tick(tick), .startup_done(sdone), .irq_request(irq),
        .wake_up(wake), .sleep_ctrl(slp));
    eipu_pin_source i_eipu_pin_source (.clk, .pin_lvl, .pin_a, .pin_b);

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Called just after an edge; ends one edge after release so no signal is set twice
    // Waits for the answer however long it takes; only the watchdog ends a hang
    task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        avs_address <= a;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= {24'h0, d};
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'h0);
        q = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
        @(posedge clk);
    endtask : bus

    task tick_once;
        tick <= 1'h1;
        @(posedge clk);
        tick <= 1'h0;
        repeat (2) @(posedge clk);
    endtask : tick_once

    task t_regs;
        bus(1'h0, 4'h0, 8'h00);
        chk("ctrl reset", q, 32'h0);
        bus(1'h1, 4'h0, 8'hff);
        bus(1'h0, 4'h0, 8'h00);
        chk("ctrl rw", q, 32'hff);
        chk("sleep bits", 32'(slp), 32'hf);
        bus(1'h1, 4'h1, 8'h55);
        bus(1'h0, 4'h1, 8'h00);
        chk("unmapped", q, 32'h0);
    endtask : t_regs

    task t_edges;
        glb <= 1'h1;
        bus(1'h1, 4'h4, 8'hc0);
        for (int p = 0; p < 2; p++) begin
            for (int m = 1; m < 4; m++) begin
                bus(1'h1, 4'h0, 8'(m << (2 * p)));
                bus(1'h0, 4'h8, 8'h00);
                chk("flag on mode change", q, 32'h0);
                pin_lvl[p] <= 1'h0;
                repeat (6) @(posedge clk);
                bus(1'h0, 4'h8, 8'h00);
                chk("flag after fall", q, 32'(m != 3) << (6 + p));
                chk("request after fall", 32'(irq[p]), 32'(m != 3));
                bus(1'h1, 4'h8, 8'h00);
                bus(1'h0, 4'h8, 8'h00);
                chk("flag write zero", q, 32'(m != 3) << (6 + p));
                bus(1'h1, 4'h8, 8'hc0);
                pin_lvl[p] <= 1'h1;
                repeat (6) @(posedge clk);
                bus(1'h0, 4'h8, 8'h00);
                chk("flag after rise", q, 32'(m != 2) << (6 + p));
                vec[p] <= 1'h1;
                @(posedge clk);
                vec <= 2'h0;
                bus(1'h0, 4'h8, 8'h00);
                chk("flag vector clear", q, 32'h0);
            end
        end
    endtask : t_edges

    task t_ioclk;
        ioc <= 1'h0;
        bus(1'h1, 4'h0, 8'h02);
        pin_lvl <= 2'h2;
        repeat (6) @(posedge clk);
        bus(1'h0, 4'h8, 8'h00);
        chk("edge with clock stopped", q, 32'h0);
        ioc <= 1'h1;
        pin_lvl <= 2'h3;
        repeat (6) @(posedge clk);
    endtask : t_ioclk

    task t_level;
        bus(1'h1, 4'h0, 8'h02);
        pin_lvl <= 2'h2;
        repeat (10) @(posedge clk);
        // Flag was set by the fall; level mode must hide it, clock stopped
        ioc <= 1'h0;
        bus(1'h1, 4'h0, 8'h00);
        chk("level request", 32'(irq), 32'h1);
        bus(1'h0, 4'h8, 8'h00);
        chk("level flag", q, 32'h0);
        bus(1'h0, 4'hc, 8'h00);
        chk("status", q, 32'h5);
        glb <= 1'h0;
        repeat (2) @(posedge clk);
        chk("global off", 32'(irq), 32'h0);
        glb <= 1'h1;
        bus(1'h1, 4'h4, 8'h80);
        chk("pin a disabled", 32'(irq), 32'h0);
        pin_lvl <= 2'h0;
        repeat (3) @(posedge clk);
        chk("pin b level", 32'(irq), 32'h2);
        pin_lvl <= 2'h3;
        ioc <= 1'h1;
        bus(1'h1, 4'h4, 8'hc0);
    endtask : t_level

    task t_wake;
        pdn <= 1'h1;
        pin_lvl <= 2'h2;
        repeat (2) @(posedge clk);
        tick_once;
        pin_lvl <= 2'h3;
        repeat (2) @(posedge clk);
        tick_once;
        chk("one sample no wake", 32'(wake), 32'h0);
        pin_lvl <= 2'h2;
        repeat (2) @(posedge clk);
        tick_once;
        tick_once;
        chk("two samples wake", 32'(wake), 32'h1);
        chk("level held in start-up", 32'(irq), 32'h0);
        pin_lvl <= 2'h3;
        repeat (2) @(posedge clk);
        sdone <= 1'h1;
        @(posedge clk);
        sdone <= 1'h0;
        repeat (2) @(posedge clk);
        chk("wake ends", 32'(wake), 32'h0);
        chk("no level request", 32'(irq), 32'h0);
        pin_lvl <= 2'h2;
        repeat (2) @(posedge clk);
        tick_once;
        tick_once;
        sdone <= 1'h1;
        @(posedge clk);
        sdone <= 1'h0;
        repeat (2) @(posedge clk);
        chk("held level request", 32'(irq), 32'h1);
        pin_lvl <= 2'h3;
        pdn <= 1'h0;
    endtask : t_wake

    task test_done;
        $display("errors %0d checks %0d", err_total, n_checks);
        if (err_total == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (6) @(posedge clk);
        reset_n <= 1'h1;
        @(posedge clk);
        t_regs;
        t_edges;
        t_ioclk;
        t_level;
        t_wake;
        test_done;
    end

    // Whole run is under 2000 cycles; this bound only cuts a hang short
    initial begin
        #200000;
        err_total++;
        test_done;
    end
endmodule : eipu_bench
`default_nettype wire
